// ==== clock_prescaler_pkg.sv ====
// Constants for the oscillator prescaler and speed selection block
package clock_prescaler_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] RELOAD_OFFSET        = 8'h00;
    localparam logic [7:0] CONFIG_FIRST_OFFSET  = 8'h04;
    localparam logic [7:0] CONFIG_SECOND_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET        = 8'h0C;

    // Field positions of the first configuration register
    localparam int DOUBLE_SPEED_BIT   = 0;
    localparam int TIMER0_FAST_BIT    = 1;
    localparam int TIMER1_FAST_BIT    = 2;
    localparam int TIMER2_FAST_BIT    = 3;
    localparam int SERIAL_FAST_BIT    = 4;
    localparam int COUNTER_FAST_BIT   = 5;
    localparam int WATCHDOG_FAST_BIT  = 6;
    // Field position of the second configuration register
    localparam int SPI_FAST_BIT       = 0;

    // Status register field positions
    localparam int STATUS_RELOAD_LSB  = 0;
    localparam int STATUS_X2_BIT      = 8;
    localparam int STATUS_FAST_LSB    = 9;

    // Peripheral count and indexes into the fast-select vector
    localparam int PERIPH_COUNT       = 7;
    localparam int PERIPH_SPI         = 6;

    // Reset values
    localparam logic [7:0] RELOAD_RESET = 8'hFF;
    localparam logic [6:0] FAST_RESET   = 7'h00;

    // Divider arithmetic
    localparam logic [7:0] RELOAD_ALL_ONES = 8'hFF;
    localparam logic [9:0] DIV_FAST_X2     = 10'h001;
    localparam logic [9:0] DIV_FAST_STD    = 10'h002;

    // Divided-clock periods per instruction and per peripheral cycle
    localparam logic [3:0] PERIODS_SHORT = 4'h6;
    localparam logic [3:0] PERIODS_LONG  = 4'hC;

    // Strap capture: edges after release before the synchroniser is valid
    localparam logic [1:0] STRAP_LOAD_COUNT = 2'h2;
    localparam logic [1:0] STRAP_DONE_COUNT = 2'h3;

endpackage

// ==== periph_cycle_divider.sv ====
// Counts divided-clock ticks into instruction or peripheral cycles
`timescale 1ns/1ps
`default_nettype none
module periph_cycle_divider
    import clock_prescaler_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic base_tick,
    input  wire logic long_mode,
    output logic      cycle_pulse
);

    logic [3:0] cnt_r;
    logic [3:0] limit_r;
    logic       wrap;

    // Last tick of the current cycle
    assign wrap        = base_tick && (cnt_r == limit_r - 4'h1);
    assign cycle_pulse = wrap;

    // Mode is taken only when a cycle closes, so no cycle is cut short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r   <= 4'h0;
            limit_r <= PERIODS_SHORT;
        end else if (wrap) begin
            cnt_r   <= 4'h0;
            limit_r <= long_mode ? PERIODS_LONG : PERIODS_SHORT;
        end else if (base_tick) begin
            cnt_r   <= cnt_r + 4'h1;
        end
    end

endmodule
`default_nettype wire

// ==== clock_prescaler_speed_select.sv ====
// Oscillator prescaler with global and per-peripheral double-speed selection
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module clock_prescaler_speed_select
    import clock_prescaler_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        security_double_speed,
    output logic             cpu_clock_tick,
    output logic             instruction_tick,
    output logic [6:0]       peripheral_tick,
    output logic             double_speed_active
);

    // Software-visible settings
    logic [7:0] clock_divider_reload_r;
    logic       double_speed_select_r;
    logic [6:0] fast_select_r;

    // Settings in force for the current divided period
    logic [7:0] active_reload_r;
    logic       active_x2_r;
    logic [6:0] active_fast_r;

    // Prescaler counter
    logic [9:0] div_cnt_r;
    logic [9:0] div_nxt;

    // Strap synchroniser and capture
    logic       hsb_sync1_r;
    logic       hsb_sync2_r;
    logic [1:0] strap_cnt_r;

    // Bus decode and response
    logic        setup_phase;
    logic        access_done;
    logic        wr_reload;
    logic        wr_first;
    logic        wr_second;
    logic        addr_hit;
    logic        addr_ro;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic [31:0] rd_mux;
    logic [6:0]  eff_fast;

    // Division ratio for a reload value and speed mode
    function automatic logic [9:0] divisor_of(input logic [7:0] r, input logic x2);
        logic [7:0] diff;
        diff = RELOAD_ALL_ONES - r;
        if (r == RELOAD_ALL_ONES) begin
            divisor_of = x2 ? DIV_FAST_X2 : DIV_FAST_STD;
        end else if (x2) begin
            divisor_of = {1'b0, diff, 1'b0};
        end else begin
            divisor_of = {diff, 2'b00};
        end
    endfunction

    // APB phase decode
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable;
    assign pready      = access_done;
    assign pslverr     = pslverr_r;
    assign prdata      = prdata_r;
    assign wr_reload   = access_done && pwrite && !pslverr_r && (paddr == RELOAD_OFFSET);
    assign wr_first    = access_done && pwrite && !pslverr_r && (paddr == CONFIG_FIRST_OFFSET);
    assign wr_second   = access_done && pwrite && !pslverr_r && (paddr == CONFIG_SECOND_OFFSET);
    assign addr_hit    = (paddr == RELOAD_OFFSET) || (paddr == CONFIG_FIRST_OFFSET) ||
                         (paddr == CONFIG_SECOND_OFFSET) || (paddr == STATUS_OFFSET);
    assign addr_ro     = (paddr == STATUS_OFFSET);

    // Fast bits gated by the global mode in force
    assign eff_fast = active_x2_r ? active_fast_r : 7'h00;

    // Read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            RELOAD_OFFSET: begin
                rd_mux[7:0] = clock_divider_reload_r;
            end
            CONFIG_FIRST_OFFSET: begin
                rd_mux[DOUBLE_SPEED_BIT]  = double_speed_select_r;
                rd_mux[TIMER0_FAST_BIT]   = fast_select_r[0];
                rd_mux[TIMER1_FAST_BIT]   = fast_select_r[1];
                rd_mux[TIMER2_FAST_BIT]   = fast_select_r[2];
                rd_mux[SERIAL_FAST_BIT]   = fast_select_r[3];
                rd_mux[COUNTER_FAST_BIT]  = fast_select_r[4];
                rd_mux[WATCHDOG_FAST_BIT] = fast_select_r[5];
            end
            CONFIG_SECOND_OFFSET: begin
                rd_mux[SPI_FAST_BIT] = fast_select_r[PERIPH_SPI];
            end
            STATUS_OFFSET: begin
                rd_mux[STATUS_RELOAD_LSB +: 8]        = active_reload_r;
                rd_mux[STATUS_X2_BIT]                 = active_x2_r;
                rd_mux[STATUS_FAST_LSB +: PERIPH_COUNT] = eff_fast;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data and error are captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_phase) begin
            prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_r <= !addr_hit || (pwrite && addr_ro);
        end
    end

    // Reload register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_divider_reload_r <= RELOAD_RESET;
        end else if (wr_reload) begin
            clock_divider_reload_r <= pwdata[7:0];
        end
    end

    // Strap pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hsb_sync1_r <= 1'b0;
            hsb_sync2_r <= 1'b0;
        end else begin
            hsb_sync1_r <= security_double_speed;
            hsb_sync2_r <= hsb_sync1_r;
        end
    end

    // Strap capture counter, runs once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_cnt_r <= 2'h0;
        end else if (strap_cnt_r != STRAP_DONE_COUNT) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end

    // Global double-speed bit: strap at start-up, then software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            double_speed_select_r <= 1'b0;
        end else if (strap_cnt_r == STRAP_LOAD_COUNT) begin
            double_speed_select_r <= hsb_sync2_r;
        end else if (wr_first) begin
            double_speed_select_r <= pwdata[DOUBLE_SPEED_BIT];
        end
    end

    // Peripheral fast-select bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_select_r <= FAST_RESET;
        end else begin
            if (wr_first) begin
                fast_select_r[0] <= pwdata[TIMER0_FAST_BIT];
                fast_select_r[1] <= pwdata[TIMER1_FAST_BIT];
                fast_select_r[2] <= pwdata[TIMER2_FAST_BIT];
                fast_select_r[3] <= pwdata[SERIAL_FAST_BIT];
                fast_select_r[4] <= pwdata[COUNTER_FAST_BIT];
                fast_select_r[5] <= pwdata[WATCHDOG_FAST_BIT];
            end
            if (wr_second) begin
                fast_select_r[PERIPH_SPI] <= pwdata[SPI_FAST_BIT];
            end
        end
    end

    // Divisor for the next period, from the pending settings
    assign div_nxt        = divisor_of(clock_divider_reload_r, double_speed_select_r);
    assign cpu_clock_tick = (div_cnt_r == 10'h000);

    // Prescaler countdown; a tick closes each divided period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 10'h000;
        end else if (cpu_clock_tick) begin
            div_cnt_r <= div_nxt - 10'h001;
        end else begin
            div_cnt_r <= div_cnt_r - 10'h001;
        end
    end

    // Settings move into force only at a period boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_reload_r <= RELOAD_RESET;
            active_x2_r     <= 1'b0;
            active_fast_r   <= FAST_RESET;
        end else if (cpu_clock_tick) begin
            active_reload_r <= clock_divider_reload_r;
            active_x2_r     <= double_speed_select_r;
            active_fast_r   <= fast_select_r;
        end
    end

    assign double_speed_active = active_x2_r;

    // Instruction cycle: six divided periods (twelve oscillator periods in standard with reload FF)
    periph_cycle_divider u_instr_div (
        .pclk        (pclk),
        .presetn     (presetn),
        .base_tick   (cpu_clock_tick),
        .long_mode   (1'b0),
        .cycle_pulse (instruction_tick)
    );

    // One cycle divider per peripheral
    genvar gi;
    generate
        for (gi = 0; gi < PERIPH_COUNT; gi = gi + 1) begin : g_periph
            periph_cycle_divider u_div (
                .pclk        (pclk),
                .presetn     (presetn),
                .base_tick   (cpu_clock_tick),
                .long_mode   (active_x2_r && !eff_fast[gi]),
                .cycle_pulse (peripheral_tick[gi])
            );
        end
    endgenerate

    // Checking helpers: cycles since last tick, first tick and reload write seen
    logic [9:0] period_cnt_r;
    logic       seen_tick_r;
    logic       seen_reload_wr_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_cnt_r     <= 10'h000;
            seen_tick_r      <= 1'b0;
            seen_reload_wr_r <= 1'b0;
        end else begin
            period_cnt_r     <= cpu_clock_tick ? 10'h000 : period_cnt_r + 10'h001;
            seen_tick_r      <= seen_tick_r || cpu_clock_tick;
            seen_reload_wr_r <= seen_reload_wr_r || wr_reload;
        end
    end

    // Cycles a set global bit has waited to come into force
    logic [10:0] x2_wait_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x2_wait_r <= 11'h000;
        end else if (double_speed_select_r && !active_x2_r) begin
            x2_wait_r <= x2_wait_r + 11'h001;
        end else begin
            x2_wait_r <= 11'h000;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Reload register contents and refused writes
    a_reload_reset_value: assert property (
        !seen_reload_wr_r |-> clock_divider_reload_r == 8'hFF)
        else $error("reload not all ones before first write");
    a_reload_write_taken: assert property (
        wr_reload |=> clock_divider_reload_r == $past(pwdata[7:0]))
        else $error("reload write not stored");
    a_error_no_store: assert property (
        (access_done && pslverr_r) |=> $stable(clock_divider_reload_r) && $stable(fast_select_r))
        else $error("refused write changed a setting");

    // Period checks against the settings in force
    a_slowest_standard: assert property (
        (cpu_clock_tick && seen_tick_r && active_reload_r == 8'h00 && !active_x2_r)
        |-> period_cnt_r == 10'd1019)
        else $error("slowest standard period not 1020");
    a_slowest_double: assert property (
        (cpu_clock_tick && seen_tick_r && active_reload_r == 8'h00 && active_x2_r)
        |-> period_cnt_r == 10'd509)
        else $error("slowest double-speed period not 510");
    a_fastest_modes: assert property (
        (cpu_clock_tick && seen_tick_r && active_reload_r == 8'hFF)
        |-> period_cnt_r == (active_x2_r ? 10'd0 : 10'd1))
        else $error("fastest period wrong");
    a_double_ratio: assert property (
        (cpu_clock_tick && seen_tick_r && active_x2_r && active_reload_r != 8'hFF)
        |-> period_cnt_r + 10'd1 == {1'b0, 8'hFF - active_reload_r, 1'b0})
        else $error("double-speed period wrong");
    a_standard_ratio: assert property (
        (cpu_clock_tick && seen_tick_r && !active_x2_r && active_reload_r != 8'hFF)
        |-> period_cnt_r + 10'd1 == {8'hFF - active_reload_r, 2'b00})
        else $error("standard period wrong");

    // Global mode entry, strap capture and boundary timing
    a_x2_set_enters: assert property (
        x2_wait_r <= 11'd1020)
        else $error("double-speed not entered");
    a_strap_loaded: assert property (
        (strap_cnt_r == 2'h2) |=> double_speed_select_r == $past(hsb_sync2_r))
        else $error("strap not captured");
    a_boundary_only: assert property (
        !cpu_clock_tick |=> $stable(active_reload_r) && $stable(active_x2_r))
        else $error("settings changed mid-period");

    // Instruction and peripheral cycles
    a_fast_gated: assert property (
        !active_x2_r |-> eff_fast == 7'h00)
        else $error("fast bits active outside double speed");
    a_instr_spacing: assert property (
        instruction_tick |=> !instruction_tick [*5])
        else $error("instruction cycle shorter than six periods");
    a_periph_spacing: assert property (
        peripheral_tick[0] |=> !peripheral_tick[0] [*5])
        else $error("peripheral cycle shorter than six periods");

    c_slowest_std: cover property (cpu_clock_tick && active_reload_r == 8'h00 && !active_x2_r);
    c_double_fast: cover property (cpu_clock_tick && active_reload_r == 8'hFF && active_x2_r);
    c_periph_fast: cover property (peripheral_tick[0] && eff_fast[0]);
    c_periph_slow: cover property (peripheral_tick[0] && active_x2_r && !eff_fast[0]);
    c_strap_double: cover property (strap_cnt_r == STRAP_LOAD_COUNT && hsb_sync2_r);

endmodule
`default_nettype wire

// ==== test_clock_prescaler_speed_select.sv ====
// Self-checking bench for the oscillator prescaler and speed selection block
`timescale 1ns/1ps
`default_nettype none
module test_clock_prescaler_speed_select;
    import clock_prescaler_pkg::*;

    localparam logic [7:0] UNMAPPED = 8'h10;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        security_double_speed;
    logic        cpu_clock_tick;
    logic        instruction_tick;
    logic [6:0]  peripheral_tick;
    logic        double_speed_active;
    logic [8:0]  ticks;
    logic [31:0] rd;
    logic        er;
    logic [7:0]  rl [3] = '{8'h00, 8'hFE, 8'h80};
    int          cnt [9];
    int          gap [9];
    int          fails;
    int          checks_done;

    clock_prescaler_speed_select clock_prescaler_speed_select_i (
        .pclk                  (pclk),
        .presetn               (presetn),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .paddr                 (paddr),
        .pwdata                (pwdata),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .security_double_speed (security_double_speed),
        .cpu_clock_tick        (cpu_clock_tick),
        .instruction_tick      (instruction_tick),
        .peripheral_tick       (peripheral_tick),
        .double_speed_active   (double_speed_active)
    );

    // 25 MHz oscillator
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // Index 0 cpu tick, 1 instruction tick, 2 and up peripheral ticks
    assign ticks = {peripheral_tick, instruction_tick, cpu_clock_tick};

    // Cycles between successive pulses of each tick output
    always @(negedge pclk) begin
        for (int i = 0; i < 9; i++) begin
            cnt[i] = cnt[i] + 1;
            if (ticks[i] === 1'b1) begin
                gap[i] = cnt[i];
                cnt[i] = 0;
            end
        end
    end

    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read with expected data and no error
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, er);
        check(name, rd, exp);
        check("read pslverr", {31'h0, er}, 32'h0000_0000);
    endtask

    // Write with expected error response
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic e_exp);
        apb(1'b1, a, d, rd, er);
        check("write pslverr", {31'h0, er}, {31'h0, e_exp});
    endtask

    // Global speed bit and peripheral fast bits in one go
    task automatic set_fast(input logic [6:0] f, input logic x2);
        wr_chk(CONFIG_FIRST_OFFSET, {25'h0, f[5:0], x2}, 1'b0);
        wr_chk(CONFIG_SECOND_OFFSET, {31'h0, f[6]}, 1'b0);
    endtask

    // Wait for n pulses of one tick output
    task automatic wait_ticks(input int idx, input int n);
        repeat (n) begin
            @(negedge pclk);
            while (ticks[idx] !== 1'b1) @(negedge pclk);
        end
    endtask

    // Settle on a new setting, then compare the pulse spacing
    task automatic period(input string name, input int idx, input int exp);
        wait_ticks(idx, 3);
        #1;
        check(name, gap[idx], exp);
    endtask

    task automatic do_reset(input logic strap);
        @(posedge pclk);
        presetn               <= 1'b0;
        security_double_speed <= strap;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask

    // Main sequence
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        security_double_speed = 1'b0;
        do_reset(1'b0);
        rd_chk("reload reset", RELOAD_OFFSET, 32'h0000_00FF);
        rd_chk("status reset", STATUS_OFFSET, 32'h0000_00FF);
        period("cpu std FF", 0, 2);
        period("instr std FF", 1, 12);
        set_fast(7'h7F, 1'b0);
        rd_chk("config first", CONFIG_FIRST_OFFSET, 32'h0000_007E);
        rd_chk("status gated", STATUS_OFFSET, 32'h0000_00FF);
        for (int i = 0; i < 7; i++) begin
            period("periph std", 2 + i, 12);
        end
        set_fast(7'h00, 1'b1);
        period("cpu x2 FF", 0, 1);
        check("x2 active", {31'h0, double_speed_active}, 32'h0000_0001);
        period("instr x2 FF", 1, 6);
        for (int i = 0; i < 7; i++) begin
            set_fast(7'(1 << i), 1'b1);
            period("periph fast", 2 + i, 6);
            period("periph slow", 2 + (i + 1) % 7, 12);
            rd_chk("status fast", STATUS_OFFSET,
                   (32'h1 << (STATUS_FAST_LSB + i)) | 32'h0000_01FF);
        end
        for (int m = 1; m >= 0; m--) begin
            set_fast(7'h00, m[0]);
            for (int k = 0; k < 3; k++) begin
                wr_chk(RELOAD_OFFSET, {24'h0, rl[k]}, 1'b0);
                period("cpu div", 0, (m == 1 ? 2 : 4) * (255 - int'(rl[k])));
            end
            rd_chk("status reload", STATUS_OFFSET, {23'h0, m[0], 8'h80});
        end
        // Reload 80 then FF mid-period: old period must finish whole
        wait_ticks(0, 1);
        wr_chk(RELOAD_OFFSET, 32'h0000_00FF, 1'b0);
        wait_ticks(0, 1);
        #1;
        check("boundary gap", gap[0], 508);
        period("cpu after switch", 0, 2);
        apb(1'b0, UNMAPPED, 32'h0000_0000, rd, er);
        check("unmapped data", rd, 32'h0000_0000);
        check("unmapped err", {31'h0, er}, 32'h0000_0001);
        wr_chk(UNMAPPED, 32'h0000_0012, 1'b1);
        wr_chk(STATUS_OFFSET, 32'h0000_FFFF, 1'b1);
        rd_chk("status kept", STATUS_OFFSET, 32'h0000_00FF);
        do_reset(1'b1);
        period("cpu strap x2", 0, 1);
        check("strap active", {31'h0, double_speed_active}, 32'h0000_0001);
        rd_chk("status strap", STATUS_OFFSET, 32'h0000_01FF);
        set_fast(7'h00, 1'b0);
        period("instr back std", 1, 12);
        check("x2 cleared", {31'h0, double_speed_active}, 32'h0000_0000);
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
